// file: tap_map.svh
// tap_map.svh: offsets, codes, field positions and counts for the test port
// assumes: included by the package, the test port module and the bench
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH
`define IR_LEN        10
`define IR_EXTEST     10'h000
`define IR_RECONFIG   10'h001
`define IR_SAMPLE     10'h005
`define IR_IDCODE     10'h006
`define IR_USERCODE   10'h007
`define IR_CLAMP      10'h00a
`define IR_HIGHZ      10'h00b
`define IR_CONFIG_IO  10'h00d
`define IR_IN_CIRCUIT 10'h00e
`define IR_ANALYZER   10'h00f
`define IR_BYPASS     10'h3ff
`define IR_CAPT       10'h001
`define ID_LEN        32
`define ID_VER_LSB    28
`define ID_PART_LSB   12
`define ID_MFR_LSB    1
`define CFGW_LEN      8
`endif

// file: tap_pkg.sv
// tap_pkg.sv: types shared by the test port
// assumes: tap_map.svh sits in the same folder
`include "tap_map.svh"
package tap_pkg;
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} tap_state_e;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} link_s;
	typedef struct packed {
		logic [`CFGW_LEN-1:0] data;
	} cfg_word_s;
endpackage : tap_pkg

// file: tap_port.sv
// tap_port.sv: boundary-scan test access port with instruction decode and data registers
// assumes: tck/tms/tdi/pad inputs are asynchronous; config status inputs come from ref_clk_i logic
`timescale 1ns/1ns
`include "tap_map.svh"
// How it works
// - pin takeover by scan is gated off while configuration is busy
// - sample/preload captures pad values and loads a pattern for later driving
// - extest drives scan cells onto pads and captures pad inputs
// - bypass puts one flop between tdi and tdo
// - usercode shifts the 32-bit user code out on tdo
// - idcode shifts the identification code out on tdo
// - highz selects bypass and floats every pad
// - clamp selects bypass and holds pads at scan-cell levels
// - reconfig instruction pulses a config request, physical pin untouched
// - config_io loads pad standards; aborts a running configuration
// - after config_io the status pin is held low until reconfigured
// - pll bits join the chain only until configuration completes
// - in-circuit reconfig instruction streams words to the config engine
// - analyzer instruction hands shifts to the embedded logic analyzer
// - user code comes from configuration data
// - instruction register is 10 bits, user code register 32 bits
// - idcode is version, part, maker code, and lsb one
// - enabled keepers override the float of highz, clamp and extest
module tap_port #(
	parameter int NPINS = 8,
	parameter int PLLW = 4,
	parameter int STDW = 2,
	parameter logic [3:0] VERSION = 4'h0,   // arbitrary
	parameter logic [15:0] PART = 16'h1234, // arbitrary
	parameter logic [10:0] MAKER = 11'h2aa  // arbitrary
) (
	input  wire logic             ref_clk_i,     // 125 MHz clock
	input  wire logic             rst_n_i,       // sync reset, low
	input  wire logic             tck_i,         // test clock pin
	input  wire logic             tms_i,         // test mode select pin
	input  wire logic             tdi_i,         // test data in pin
	output logic                  tdo_o,         // test data out
	output logic                  tdo_oe_o,      // tdo driven
	input  wire logic [NPINS-1:0] core_o_i,      // core pad data
	input  wire logic [NPINS-1:0] core_oe_i,     // core pad enable
	input  wire logic [NPINS-1:0] keeper_en_i,   // bus hold or pull-up on
	input  wire logic [NPINS-1:0] pad_i,         // pad levels in
	output logic [NPINS-1:0]      pad_o,         // pad data out
	output logic [NPINS-1:0]      pad_oe_o,      // pad enable out
	output logic [NPINS-1:0]      pad_keep_o,    // keeper holds pad
	output logic [NPINS-1:0]      core_i_o,      // pad levels to core
	input  wire logic             config_busy_i, // configuration running
	input  wire logic             config_done_i, // device configured
	input  wire logic [31:0]      usercode_i,    // from config data
	input  wire logic [PLLW-1:0]  pll_init_i,    // pll bits at power-up
	output logic [PLLW-1:0]       pll_bits_o,    // pll bits from chain
	output logic [STDW*NPINS-1:0] io_std_o,      // pad standards
	output logic                  reconfig_o,    // config request pulse
	output logic                  cfg_abort_o,   // abort pulse
	output logic                  status_low_o,  // hold status pin low
	output tap_pkg::cfg_word_s    cfgw_data_o,   // config word out
	output logic                  cfgw_valid_o,  // word valid
	input  wire logic             cfgw_ready_i,  // engine takes word
	output logic                  la_sel_o,      // analyzer selected
	output logic                  la_shift_o,    // analyzer shift pulse
	output logic                  la_update_o,   // analyzer update pulse
	output logic                  la_tdi_o,      // analyzer data in
	input  wire logic             la_tdo_i       // analyzer data out
);
	localparam int BSRW = 3 * NPINS;
	localparam int DRW = BSRW + PLLW > STDW * NPINS ? BSRW + PLLW : STDW * NPINS;
	localparam int W = DRW > 32 ? DRW : 32;

	// two flops on every pin input; the third tck flop only feeds edge detection
	tap_pkg::link_s lk1_q, lk2_q;
	logic [NPINS-1:0] pad1_q, pad2_q;
	logic tck3_q;
	always_ff @(posedge ref_clk_i) begin
		lk1_q <= '{tck: tck_i, tms: tms_i, tdi: tdi_i};
		lk2_q <= lk1_q;
		tck3_q <= lk2_q.tck;
		pad1_q <= pad_i;
		pad2_q <= pad1_q;
	end
	wire rise = lk2_q.tck & ~tck3_q;
	wire fall = ~lk2_q.tck & tck3_q;

	// controller state walk, advanced on each sampled rising tck
	tap_pkg::tap_state_e st_q, st_d;
	wire tms = lk2_q.tms;
	always_comb begin
		case (st_q)
			tap_pkg::TLR:    st_d = tms ? tap_pkg::TLR : tap_pkg::RTI;
			tap_pkg::RTI:    st_d = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
			tap_pkg::SEL_DR: st_d = tms ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
			tap_pkg::CAP_DR: st_d = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
			tap_pkg::SH_DR:  st_d = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
			tap_pkg::EX1_DR: st_d = tms ? tap_pkg::UPD_DR : tap_pkg::PA_DR;
			tap_pkg::PA_DR:  st_d = tms ? tap_pkg::EX2_DR : tap_pkg::PA_DR;
			tap_pkg::EX2_DR: st_d = tms ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
			tap_pkg::UPD_DR: st_d = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
			tap_pkg::SEL_IR: st_d = tms ? tap_pkg::TLR : tap_pkg::CAP_IR;
			tap_pkg::CAP_IR: st_d = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
			tap_pkg::SH_IR:  st_d = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
			tap_pkg::EX1_IR: st_d = tms ? tap_pkg::UPD_IR : tap_pkg::PA_IR;
			tap_pkg::PA_IR:  st_d = tms ? tap_pkg::EX2_IR : tap_pkg::PA_IR;
			tap_pkg::EX2_IR: st_d = tms ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
			tap_pkg::UPD_IR: st_d = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
			default:         st_d = tap_pkg::TLR;
		endcase
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			st_q <= tap_pkg::TLR;
		else if (rise)
			st_q <= st_d;
	end

	// one-cycle actions tied to the rising edge that leaves each state
	wire cap_dr = rise & (st_q == tap_pkg::CAP_DR);
	wire sh_dr  = rise & (st_q == tap_pkg::SH_DR);
	wire upd_dr = rise & (st_q == tap_pkg::UPD_DR);
	wire cap_ir = rise & (st_q == tap_pkg::CAP_IR);
	wire sh_ir  = rise & (st_q == tap_pkg::SH_IR);
	wire upd_ir = rise & (st_q == tap_pkg::UPD_IR);

	// instruction decode; unknown codes fall back to bypass
	logic [`IR_LEN-1:0] ir_sh_q, ir_q;
	wire i_ext  = ir_q == `IR_EXTEST;
	wire i_smp  = ir_q == `IR_SAMPLE;
	wire i_id   = ir_q == `IR_IDCODE;
	wire i_usr  = ir_q == `IR_USERCODE;
	wire i_clmp = ir_q == `IR_CLAMP;
	wire i_hiz  = ir_q == `IR_HIGHZ;
	wire i_cio  = ir_q == `IR_CONFIG_IO;
	wire i_inc  = ir_q == `IR_IN_CIRCUIT;
	wire i_la   = ir_q == `IR_ANALYZER;
	wire i_bsr  = i_ext | i_smp;
	wire i_byp  = ~(i_bsr | i_id | i_usr | i_cio | i_inc | i_la);
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ir_sh_q <= `IR_CAPT;
			ir_q <= `IR_IDCODE;
		end else if (rise && st_q == tap_pkg::TLR) begin
			ir_q <= `IR_IDCODE;
		end else begin
			if (cap_ir)
				ir_sh_q <= `IR_CAPT;
			else if (sh_ir)
				ir_sh_q <= {lk2_q.tdi, ir_sh_q[`IR_LEN-1:1]};
			if (upd_ir)
				ir_q <= ir_sh_q;
		end
	end

	// one shared data shift path; its length follows the instruction
	wire pll_in = ~config_done_i;
	wire [31:0] idcode = {VERSION, PART, MAKER, 1'b1};
	logic [W-1:0] dr_q, dr_d, cap_v;
	logic [BSRW-1:0] bsr_q;
	logic [PLLW-1:0] pll_q;
	logic [STDW*NPINS-1:0] std_q;
	logic byp_q;
	logic [1:0] fcnt_q;
	int len;
	always_comb begin
		len = 1;
		cap_v = '0;
		if (i_id) begin
			len = `ID_LEN;
			cap_v[31:0] = idcode;
		end else if (i_usr) begin
			len = 32;
			cap_v[31:0] = usercode_i;
		end else if (i_bsr) begin
			len = pll_in ? BSRW + PLLW : BSRW;
			for (int p = 0; p < NPINS; p++) begin
				cap_v[3*p] = pad2_q[p];
				cap_v[3*p+1] = core_o_i[p];
				cap_v[3*p+2] = core_oe_i[p];
			end
			cap_v[BSRW +: PLLW] = pll_q;
		end else if (i_cio) begin
			len = STDW * NPINS;
			cap_v[STDW*NPINS-1:0] = std_q;
		end else if (i_inc) begin
			len = `CFGW_LEN;
			cap_v[0] = fcnt_q != 2'h2;
		end
		for (int b = 0; b < W; b++)
			dr_d[b] = (b == len - 1) ? lk2_q.tdi : (b < len - 1 ? dr_q[b+1] : 1'b0);
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			dr_q <= '0;
			byp_q <= 1'b0;
		end else if (cap_dr) begin
			dr_q <= cap_v;
			byp_q <= 1'b0;
		end else if (sh_dr) begin
			dr_q <= dr_d;
			byp_q <= lk2_q.tdi;
		end
	end

	// update stage: scan cells, pll bits, pad standards
	wire [STDW*NPINS-1:0] std_rst = '0;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			bsr_q <= '0;
			pll_q <= '0;
			std_q <= std_rst;
		end else if (rise && st_q == tap_pkg::TLR && pll_in) begin
			pll_q <= pll_init_i;
		end else if (upd_dr) begin
			if (i_bsr)
				bsr_q <= dr_q[BSRW-1:0];
			if (i_bsr && pll_in)
				pll_q <= dr_q[BSRW +: PLLW];
			if (i_cio)
				std_q <= dr_q[STDW*NPINS-1:0];
		end
	end
	assign pll_bits_o = pll_q;
	assign io_std_o = std_q;

	// pad muxing; scan takeover never during configuration
	wire take = ~config_busy_i & (i_ext | i_clmp | i_hiz);
	wire [NPINS-1:0] cell_o, cell_oe;
	for (genvar p = 0; p < NPINS; p++) begin : g_pad
		assign cell_o[p] = bsr_q[3*p+1];
		assign cell_oe[p] = bsr_q[3*p+2] & ~i_hiz;
	end
	assign pad_o = take ? cell_o : core_o_i;
	assign pad_oe_o = take ? cell_oe : core_oe_i;
	assign pad_keep_o = take ? keeper_en_i & ~cell_oe : '0;
	assign core_i_o = pad2_q;

	// config requests as single-cycle pulses; status hold ends on completion
	logic done_q;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			reconfig_o <= 1'b0;
			cfg_abort_o <= 1'b0;
			status_low_o <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= config_done_i;
			reconfig_o <= upd_ir && ir_sh_q == `IR_RECONFIG;
			cfg_abort_o <= upd_ir && ir_sh_q == `IR_CONFIG_IO && config_busy_i;
			if (upd_ir && ir_sh_q == `IR_CONFIG_IO)
				status_low_o <= 1'b1;
			else if (config_done_i && !done_q)
				status_low_o <= 1'b0;
		end
	end

	// two-entry buffer toward the config engine; capture reports room so
	// the controller polls instead of losing a word it cannot stall tck for
	tap_pkg::cfg_word_s buf_q [2];
	logic rd_q, wr_q;
	wire push = upd_dr & i_inc & (fcnt_q != 2'h2);
	wire pop = cfgw_valid_o & cfgw_ready_i;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			fcnt_q <= 2'h0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			if (push) begin
				buf_q[wr_q] <= '{data: dr_q[`CFGW_LEN-1:0]};
				wr_q <= ~wr_q;
			end
			if (pop)
				rd_q <= ~rd_q;
			fcnt_q <= fcnt_q + 2'(push) - 2'(pop);
		end
	end
	assign cfgw_valid_o = fcnt_q != 2'h0;
	assign cfgw_data_o = buf_q[rd_q];

	// analyzer handoff
	assign la_sel_o = i_la;
	assign la_shift_o = sh_dr & i_la;
	assign la_update_o = upd_dr & i_la;
	assign la_tdi_o = lk2_q.tdi;

	// tdo moves on falling tck, enabled only in the shift states
	wire dr_bit = i_byp ? byp_q : (i_la ? la_tdo_i : dr_q[0]);
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tdo_o <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else if (fall) begin
			tdo_o <= st_q == tap_pkg::SH_IR ? ir_sh_q[0] : dr_bit;
			tdo_oe_o <= st_q == tap_pkg::SH_IR || st_q == tap_pkg::SH_DR;
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_tdo_only_shift: assert property (tdo_oe_o |-> $past(st_q) inside
		{tap_pkg::SH_DR, tap_pkg::SH_IR, tap_pkg::EX1_DR, tap_pkg::EX1_IR})
		else $error("tdo driven outside shift");
	a_tdo_en_shift: assert property (fall && st_q == tap_pkg::SH_DR |=> tdo_oe_o)
		else $error("tdo not driven in shift");
	a_ir_capture: assert property (cap_ir |=> ir_sh_q == `IR_CAPT)
		else $error("ir capture pattern wrong");
	a_idcode_cap: assert property (cap_dr && i_id |=> dr_q[31:0] == idcode && dr_q[0])
		else $error("idcode not captured");
	a_user_cap: assert property (cap_dr && i_usr |=> dr_q[31:0] == $past(usercode_i))
		else $error("usercode not captured");
	a_bypass_stage: assert property (sh_dr && i_byp |=> byp_q == $past(lk2_q.tdi))
		else $error("bypass stage wrong");
	a_highz_float: assert property (i_hiz && !config_busy_i |-> pad_oe_o == '0)
		else $error("pad driven in highz");
	a_clamp_hold: assert property (i_clmp && !config_busy_i |-> pad_o == cell_o)
		else $error("clamp level wrong");
	a_busy_release: assert property (config_busy_i |-> pad_oe_o == core_oe_i)
		else $error("scan took pads while busy");
	a_reconfig_pulse: assert property (upd_ir && ir_sh_q == `IR_RECONFIG
		|=> reconfig_o ##1 !reconfig_o) else $error("reconfig pulse wrong");
	a_status_hold: assert property (status_low_o && !(config_done_i && !done_q)
		|=> status_low_o) else $error("status released early");
	a_abort_busy: assert property (cfg_abort_o |-> $past(config_busy_i))
		else $error("abort without configuration");
	c_idcode_read: cover property (cap_dr && i_id ##[1:400] sh_dr);
	c_cfgw_full: cover property (fcnt_q == 2'h2);
	c_config_io: cover property ($rose(status_low_o));
endmodule : tap_port

// file: jtag_host.sv
// jtag_host.sv: behavioural board-side scan controller driving tck, tms and tdi
// assumes: ref_clk_i is the block clock; tck runs at 80 ns only inside frames
`timescale 1ns/1ns
module jtag_host (
	input  wire logic ref_clk_i, // block clock, paces the pins
	input  wire logic tdo_i,     // scan data from the block
	output logic      tck_o,     // test clock, low between frames
	output logic      tms_o,     // mode select
	output logic      tdi_o      // scan data to the block
);
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end

	// one tck period of 10 block clocks; tdo is taken just before the rise
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		@(negedge ref_clk_i);
		tms_o = tms;
		tdi_o = tdi;
		repeat (4) @(negedge ref_clk_i);
		tdo = tdo_i;
		tck_o = 1'b1;
		repeat (5) @(negedge ref_clk_i);
		tck_o = 1'b0;
	endtask : step

	// five tms-high edges always reach test-logic-reset, then park in idle
	task automatic reset_tap();
		logic t;
		repeat (5) step(1'b1, ~tdi_o, t);
		step(1'b0, ~tdi_o, t);
	endtask : reset_tap

	// idle -> capture -> shift len bits lsb first -> update -> idle
	task automatic scan(input logic ir, input logic [63:0] din, input int len,
		output logic [63:0] dout);
		logic t;
		dout = '0;
		step(1'b1, ~tdi_o, t);
		if (ir) step(1'b1, ~tdi_o, t);
		step(1'b0, ~tdi_o, t);
		step(1'b0, ~tdi_o, t);
		for (int i = 0; i < len; i++) begin
			step(i == len - 1, din[i], t);
			dout[i] = t;
		end
		step(1'b1, ~tdi_o, t);
		step(1'b0, ~tdi_o, t);
		tdi_o = ~tdi_o; // held line must not look like the last bit
	endtask : scan
endmodule : jtag_host

// file: tb_tap_port.sv
// tb_tap_port.sv: self-checking bench for the scan test port
// assumes: tap_pkg, jtag_host and tap_port are compiled first
`timescale 1ns/1ns
`include "tap_map.svh"
module tb_tap_port;
	localparam logic [3:0]  VER = 4'h3;     // arbitrary
	localparam logic [15:0] PRT = 16'h5a5a; // arbitrary
	localparam logic [10:0] MFR = 11'h155;  // arbitrary
	logic               ref_clk_i = 1'b0;
	logic               rst_n_i = 1'b0;
	logic               tck, tms, tdi, tdo, tdo_oe, la_tdo = 1'b1;
	logic [7:0]         core_o = 8'h96, core_oe = 8'hf0, keep_en = 8'h33, pad_in = 8'h5c;
	logic [7:0]         pad_o, pad_oe, pad_keep, core_i;
	logic               busy = 1'b0, done = 1'b1, cfgw_ready = 1'b0;
	logic [31:0]        ucode = 32'hc0de1234;
	logic [3:0]         pll_bits;
	logic [15:0]        io_std;
	logic               reconfig, abort, st_low, cfgw_valid, la_sel, la_sh, la_up, la_tdi;
	tap_pkg::cfg_word_s cfgw_data;
	logic [63:0]        q, v;
	logic [7:0]         got[$];
	int                 error_cnt = 0, n_checks = 0, n_rc = 0, n_ab = 0, n_sh = 0, n_up = 0, c0;

	always #4 ref_clk_i = ~ref_clk_i;

	// a released tdo reads as its pull-up level, never as the last bit
	jtag_host u_host (.ref_clk_i(ref_clk_i), .tdo_i(tdo_oe ? tdo : 1'b1), .tck_o(tck),
		.tms_o(tms), .tdi_o(tdi));

	tap_port #(.VERSION(VER), .PART(PRT), .MAKER(MFR)) u_dut (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.tdo_o(tdo), .tdo_oe_o(tdo_oe), .core_o_i(core_o), .core_oe_i(core_oe),
		.keeper_en_i(keep_en), .pad_i(pad_in), .pad_o(pad_o), .pad_oe_o(pad_oe),
		.pad_keep_o(pad_keep), .core_i_o(core_i), .config_busy_i(busy),
		.config_done_i(done), .usercode_i(ucode), .pll_init_i(4'h5),
		.pll_bits_o(pll_bits), .io_std_o(io_std), .reconfig_o(reconfig),
		.cfg_abort_o(abort), .status_low_o(st_low), .cfgw_data_o(cfgw_data),
		.cfgw_valid_o(cfgw_valid), .cfgw_ready_i(cfgw_ready), .la_sel_o(la_sel),
		.la_shift_o(la_sh), .la_update_o(la_up), .la_tdi_o(la_tdi), .la_tdo_i(la_tdo));

	// pulse counters and the drain side of the config word stream
	always @(posedge ref_clk_i) begin
		n_rc += reconfig;
		n_ab += abort;
		n_sh += la_sh;
		n_up += la_up;
		if (cfgw_valid === 1'b1 && cfgw_ready === 1'b1) got.push_back(cfgw_data.data);
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_of_test();
		if (error_cnt == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test

	task automatic ir(input logic [9:0] c);
		u_host.scan(1'b1, 64'(c), `IR_LEN, q);
		chk(q[9:0], `IR_CAPT);
	endtask : ir

	task automatic dr(input logic [63:0] d, input int n);
		u_host.scan(1'b0, d, n, q);
	endtask : dr

	task automatic t_ident();
		ir(`IR_IDCODE);
		dr(64'h0, `ID_LEN);
		chk(q[31:0], {VER, PRT, MFR, 1'b1});
		ir(`IR_USERCODE);
		dr(64'h0, 32);
		chk(q[31:0], ucode);
		chk(tdo_oe, 1'b0);
	endtask : t_ident

	// real and unknown codes that must all give a one-stage path
	task automatic t_bypass();
		logic [9:0] codes[4] = '{`IR_BYPASS, 10'h123, `IR_HIGHZ, `IR_CLAMP};
		foreach (codes[i]) begin
			ir(codes[i]);
			dr(64'hb5, 8);
			chk(q[7:0], 8'h6a);
			if (i == 0) chk(pad_oe, core_oe);
			if (i == 0) chk(pad_o, core_o);
			if (i == 2) chk(pad_oe, 8'h00);
			if (i == 2) chk(pad_keep, keep_en);
		end
	endtask : t_bypass

	task automatic t_boundary();
		v = '0;
		for (int p = 0; p < 8; p++) v[3*p+1 +: 2] = {p[0], p[1]};
		ir(`IR_SAMPLE);
		dr(v, 24);
		for (int p = 0; p < 8; p++) chk(q[3*p], pad_in[p]);
		chk(core_i, pad_in);
		ir(`IR_CLAMP);
		chk({pad_o, pad_oe}, {8'hcc, 8'haa});
		chk(pad_keep, 8'h11);
		ir(`IR_EXTEST);
		chk({pad_o, pad_oe}, {8'hcc, 8'haa});
		pad_in = 8'he1;
		dr(v, 24);
		for (int p = 0; p < 8; p++) chk(q[3*p], pad_in[p]);
		busy = 1'b1; // scan must let go of the pads while loading
		repeat (3) @(negedge ref_clk_i);
		chk(pad_oe, core_oe);
		busy = 1'b0;
		done = 1'b0;
		ir(`IR_SAMPLE);
		dr({36'h0, 4'h9, 24'h0}, 28);
		chk(pll_bits, 4'h9);
		done = 1'b1;
		dr({36'h0, 4'h6, 24'h0}, 28);
		chk(pll_bits, 4'h9);
	endtask : t_boundary

	task automatic t_config();
		c0 = n_rc;
		ir(`IR_RECONFIG);
		chk(n_rc - c0, 1);
		done = 1'b0;
		busy = 1'b1;
		c0 = n_ab;
		ir(`IR_CONFIG_IO);
		chk(n_ab - c0, 1);
		busy = 1'b0;
		dr(64'ha5c3, 16);
		chk(io_std, 16'ha5c3);
		chk(st_low, 1'b1);
		done = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		chk(st_low, 1'b0);
	endtask : t_config

	// fill the two-entry buffer with the engine stalled, then drain it
	task automatic t_incirc();
		ir(`IR_IN_CIRCUIT);
		dr(64'h3c, `CFGW_LEN);
		chk(q[0], 1'b1);
		dr(64'hc5, `CFGW_LEN);
		dr(64'h77, `CFGW_LEN);
		chk({q[0], cfgw_valid}, 2'b01);
		cfgw_ready = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		chk({got.size(), cfgw_valid}, {32'd2, 1'b0});
		chk({got[0], got[1]}, 16'h3cc5);
	endtask : t_incirc

	task automatic t_analyzer();
		ir(`IR_ANALYZER);
		chk(la_sel, 1'b1);
		c0 = n_sh + 100 * n_up;
		dr(64'h0, 5);
		chk(n_sh + 100 * n_up - c0, 105);
		chk(q[4:0], 5'h1f);
	endtask : t_analyzer

	// watchdog well beyond the expected run of about 6k block clocks
	initial begin
		#200_000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		repeat (6) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		u_host.reset_tap();
		t_ident();
		t_bypass();
		t_boundary();
		t_config();
		t_incirc();
		t_analyzer();
		end_of_test();
	end
endmodule : tb_tap_port
